// ==== bench/drive_flags_analog_input_regs_tb.sv ====
// Self-checking bench for the drive-flag, analog-input and analog-mode objects
`default_nettype none
module drive_flags_analog_input_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dfai_pkg::*;

   localparam int               TC = 2;
   // Preset gain sets, values arbitrary but distinct
   localparam logic [12*32-1:0] PS = {12{32'h0000_5a01}};
   localparam logic [12*32-1:0] PB = {12{32'h0000_a502}};

   typedef struct {
      logic [1:0]  op;
      logic [15:0] idx;
      logic [7:0]  sub;
      logic [31:0] wd;
      logic        err;
      logic [31:0] rdat;
   } dfai_row_s;

   logic                     clk;
   logic                     rst_b;
   dfai_req_s                od_req;
   dfai_rsp_s                od_rsp;
   logic                     nv_load;
   dfai_nv_s                 nv_in;
   dfai_nv_s                 nv_out;
   logic                     controller_restart;
   logic                     tune_start;
   logic                     motor_is_bldc;
   logic                     tune_busy;
   logic                     tune_done;
   logic                     tune_required;
   dfai_dir_e                field_dir;
   logic signed [15:0]       adc_one;
   logic signed [15:0]       adc_two;
   logic signed [15:0]       reading_one;
   logic signed [15:0]       reading_two;
   logic signed [31:0]       scaled_one;
   logic signed [31:0]       scaled_two;
   logic                     sel_one;
   logic                     sel_two;
   logic        [11:0][31:0] gains;
   int                       bad_count;
   int                       total_checks;

   dfai_regs #(.TUNE_CYC(TC), .PRESET_STEP(PS), .PRESET_BLDC(PB)) dut (
      .clk                       (clk),
      .rst_b                     (rst_b),
      .od_req                    (od_req),
      .od_rsp                    (od_rsp),
      .nv_load                   (nv_load),
      .nv_in                     (nv_in),
      .nv_out                    (nv_out),
      .controller_restart        (controller_restart),
      .tune_start                (tune_start),
      .motor_is_bldc             (motor_is_bldc),
      .tune_busy                 (tune_busy),
      .tune_done                 (tune_done),
      .tune_required             (tune_required),
      .field_dir                 (field_dir),
      .adc_one                   (adc_one),
      .adc_two                   (adc_two),
      .reading_one               (reading_one),
      .reading_two               (reading_two),
      .scaled_one                (scaled_one),
      .scaled_two                (scaled_two),
      .analog_in_one_current_sel (sel_one),
      .analog_in_two_current_sel (sel_two),
      .gains                     (gains)
   );

   always #5 clk = ~clk;

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One object access, entered and left at a falling edge
   task automatic acc(input logic [1:0] op, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, output logic err, output logic [31:0] rdat);
      od_req = '{rd: op[0], wr: op[1], index: idx, subindex: sub, wdata: wd};
      @(negedge clk);
      chk(32'(od_rsp.ack), 32'h1);
      err = od_rsp.err;
      rdat = od_rsp.rdata;
      od_req.rd = 1'b0;
      od_req.wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic tune(input logic [7:0] keep, input logic bldc, input logic [31:0] g0);
      int          n;
      logic        e;
      logic [31:0] d;
      acc(2'h2, 16'h3212, 8'h03, {24'h0, keep}, e, d);
      motor_is_bldc = bldc;
      tune_start = 1'b1;
      @(negedge clk);
      tune_start = 1'b0;
      chk(32'(tune_busy), 32'h1);
      n = 1;
      while (n < 10 && tune_done !== 1'b1) begin
         @(negedge clk);
         n++;
      end
      chk(32'(n), 32'(TC + 1));
      chk(32'(tune_done), 32'h1);
      chk(32'(tune_busy), 32'h0);
      @(negedge clk);
      chk(gains[0], g0);
      chk(32'(tune_required), 32'h0);
   endtask

   task automatic restart(input dfai_dir_e dir);
      controller_restart = 1'b1;
      @(negedge clk);
      controller_restart = 1'b0;
      chk(32'(field_dir), 32'(dir));
   endtask

   dfai_row_s rows[] = '{
      '{2'h1, 16'h3212, 8'h00, 32'h0, 1'b0, 32'h0000_0003},
      '{2'h1, 16'h3220, 8'h00, 32'h0, 1'b0, 32'h0000_0002},
      '{2'h1, 16'h3210, 8'h00, 32'h0, 1'b0, 32'h0000_000c},
      '{2'h1, 16'h3221, 8'h00, 32'h0, 1'b0, 32'h0000_0000},
      '{2'h1, 16'h3212, 8'h01, 32'h0, 1'b0, 32'h0000_0000},
      '{2'h1, 16'h3212, 8'h02, 32'h0, 1'b0, 32'h0000_0000},
      '{2'h1, 16'h3212, 8'h03, 32'h0, 1'b0, 32'h0000_0000},
      '{2'h2, 16'h3221, 8'h00, 32'hffff_ffff, 1'b0, 32'h0},
      '{2'h1, 16'h3221, 8'h00, 32'h0, 1'b0, 32'h0000_0003},
      '{2'h2, 16'h3212, 8'h02, 32'h0000_0001, 1'b0, 32'h0},
      '{2'h1, 16'h3212, 8'h02, 32'h0, 1'b0, 32'h0000_0001},
      '{2'h2, 16'h3212, 8'h02, 32'h0000_00ff, 1'b0, 32'h0},
      '{2'h1, 16'h3212, 8'h02, 32'h0, 1'b0, 32'hffff_ffff},
      '{2'h2, 16'h3212, 8'h02, 32'h0000_0002, 1'b1, 32'h0},
      '{2'h1, 16'h3212, 8'h02, 32'h0, 1'b0, 32'hffff_ffff},
      '{2'h2, 16'h3212, 8'h00, 32'h0000_0005, 1'b1, 32'h0},
      '{2'h2, 16'h3220, 8'h01, 32'h0000_0005, 1'b1, 32'h0},
      '{2'h1, 16'h3221, 8'h01, 32'h0, 1'b1, 32'h0},
      '{2'h1, 16'h3230, 8'h00, 32'h0, 1'b1, 32'h0},
      '{2'h2, 16'h3212, 8'h01, 32'h0000_0055, 1'b0, 32'h0},
      '{2'h1, 16'h3212, 8'h01, 32'h0, 1'b0, 32'h0000_0000},
      '{2'h2, 16'h3210, 8'h01, 32'h1234_5678, 1'b0, 32'h0},
      '{2'h1, 16'h3210, 8'h01, 32'h0, 1'b0, 32'h1234_5678},
      '{2'h2, 16'h3221, 8'h00, 32'h0000_0000, 1'b0, 32'h0}
   };

   initial begin
      #100us;
      bad_count++;
      complete_run();
   end

   initial begin
      logic        e;
      logic [31:0] d;
      int          x1;
      int          x2;
      clk = 1'b0;
      rst_b = 1'b0;
      od_req = '0;
      nv_load = 1'b0;
      nv_in = '0;
      controller_restart = 1'b0;
      tune_start = 1'b0;
      motor_is_bldc = 1'b0;
      adc_one = 16'sh0200;
      adc_two = 16'shff9c;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      chk(nv_out.amode, 32'h0);
      chk(32'({sel_two, sel_one}), 32'h0);
      chk(32'(field_dir), 32'(DFAI_DIR_FW));
      foreach (rows[i]) begin
         acc(rows[i].op, rows[i].idx, rows[i].sub, rows[i].wd, e, d);
         chk(32'(e), 32'(rows[i].err));
         if (rows[i].op == 2'h1 && !rows[i].err) chk(d, rows[i].rdat);
      end
      // Mode bits against selects and scaled readings
      for (int m = 0; m < 4; m++) begin
         acc(2'h2, 16'h3221, 8'h00, 32'(m), e, d);
         @(negedge clk);
         x1 = 512 * (m[0] ? DFAI_CURR_FS_UA : DFAI_VOLT_FS_MV) / DFAI_FS_COUNTS;
         x2 = -100 * (m[1] ? DFAI_CURR_FS_UA : DFAI_VOLT_FS_MV) / DFAI_FS_COUNTS;
         chk(32'({sel_two, sel_one}), 32'(m));
         chk(scaled_one, 32'(x1));
         chk(scaled_two, 32'(x2));
      end
      chk(32'(reading_one), 32'hffff_0200 ^ 32'hffff_0000);
      chk(32'(reading_two), 32'hffff_ff9c);
      acc(2'h1, 16'h3220, 8'h01, 32'h0, e, d);
      chk(d, 32'h0000_0200);
      acc(2'h1, 16'h3220, 8'h02, 32'h0, e, d);
      chk(d, 32'hffff_ff9c);
      // Stored override is inverted, but applies only at restart
      chk(32'(field_dir), 32'(DFAI_DIR_FW));
      restart(DFAI_DIR_NEG);
      chk(32'(tune_required), 32'h1);
      acc(2'h2, 16'h3212, 8'h02, 32'h0000_0001, e, d);
      restart(DFAI_DIR_POS);
      acc(2'h2, 16'h3212, 8'h02, 32'h0000_0000, e, d);
      restart(DFAI_DIR_FW);
      tune(8'h00, 1'b1, 32'h0000_a502);
      acc(2'h2, 16'h3210, 8'h01, 32'h0000_0abc, e, d);
      tune(8'h01, 1'b0, 32'h0000_0abc);
      acc(2'h1, 16'h3210, 8'h01, 32'h0, e, d);
      chk(d, 32'h0000_0abc);
      tune(8'h00, 1'b0, 32'h0000_5a01);
      // Restore of the savable image drops the unused mode bits
      nv_in = '{amode: 32'hffff_fffe, field: 8'h01, keep: 8'h01};
      nv_load = 1'b1;
      @(negedge clk);
      nv_load = 1'b0;
      chk(nv_out.amode, 32'h0000_0002);
      chk(32'({sel_two, sel_one}), 32'h2);
      chk(32'(nv_out.keep), 32'h1);
      chk(32'(nv_out.field), 32'h1);
      // Full-scale count on both inputs, input 1 in voltage and input 2 in current mode
      adc_one = 16'sh0400;
      adc_two = 16'sh0400;
      repeat (2) @(negedge clk);
      chk(32'(reading_two), 32'h0000_0400);
      chk(scaled_one, 32'(DFAI_VOLT_FS_MV));
      chk(scaled_two, 32'(DFAI_CURR_FS_UA));
      // Second reset in mid-run
      rst_b = 1'b0;
      @(negedge clk);
      rst_b = 1'b1;
      acc(2'h1, 16'h3221, 8'h00, 32'h0, e, d);
      chk(d, 32'h0);
      chk(32'(field_dir), 32'(DFAI_DIR_FW));
      complete_run();
   end
endmodule
`default_nettype wire

// ==== rtl/dfai_gain_store.sv ====
// Loop gain store with preset load for auto tuning
`default_nettype none
module dfai_gain_store #(
   parameter int                NUM_GAINS   = 12,
   parameter logic [12*32-1:0]  PRESET_STEP = '0,
   parameter logic [12*32-1:0]  PRESET_BLDC = '0
) (
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   input  wire logic                       wr_en,
   input  wire logic [7:0]                 wr_sub,
   input  wire logic [31:0]                wr_data,
   input  wire logic                       load_en,
   input  wire logic                       load_bldc,
   output logic      [NUM_GAINS-1:0][31:0] gains
);
   import dfai_pkg::*;

   if (NUM_GAINS != 12) begin : g_bad_gains
      $error("gain store serves exactly 12 entries");
   end

   logic [NUM_GAINS-1:0][31:0] gain_r;
   logic [NUM_GAINS-1:0][31:0] gain_nxt;

   // One entry per gain, subindex n holds entry n-1; preset load wins over a write
   always_comb begin
      gain_nxt = gain_r;
      if (load_en) begin
         gain_nxt = load_bldc ? PRESET_BLDC : PRESET_STEP;
      end else if (wr_en && wr_sub != 8'h00 && wr_sub <= 8'(NUM_GAINS)) begin
         gain_nxt[wr_sub - 8'h01] = wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gain_r <= {NUM_GAINS{DFAI_GAIN_RST}};
      end else begin
         gain_r <= gain_nxt;
      end
   end

   assign gains = gain_r;

   gain_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      !$past(load_en) && !$past(wr_en) |-> $stable(gain_r))
      else $error("gain changed without write or load");
endmodule
`default_nettype wire

// ==== rtl/dfai_pkg.sv ====
// Constants, types and carriers shared by the drive-flag and analog-input block
`default_nettype none
package dfai_pkg;
   localparam logic [15:0] DFAI_IDX_GAINS   = 16'h3210;
   localparam logic [15:0] DFAI_IDX_FLAGS   = 16'h3212;
   localparam logic [15:0] DFAI_IDX_ANALOG  = 16'h3220;
   localparam logic [15:0] DFAI_IDX_AMODE   = 16'h3221;
   localparam logic [7:0]  DFAI_SUB_COUNT   = 8'h00;
   localparam logic [7:0]  DFAI_SUB_SPARE   = 8'h01;
   localparam logic [7:0]  DFAI_SUB_FIELD   = 8'h02;
   localparam logic [7:0]  DFAI_SUB_KEEP    = 8'h03;
   localparam logic [7:0]  DFAI_SUB_AIN_ONE = 8'h01;
   localparam logic [7:0]  DFAI_SUB_AIN_TWO = 8'h02;
   localparam logic [7:0]  DFAI_FLAG_COUNT_RST   = 8'h03;
   localparam logic [7:0]  DFAI_ANALOG_COUNT_RST = 8'h02;
   localparam logic [7:0]  DFAI_GAIN_COUNT_RST   = 8'h0c;
   localparam logic [31:0] DFAI_AMODE_RST   = 32'h0000_0000;
   localparam logic [7:0]  DFAI_FIELD_RST   = 8'h00;
   localparam logic [7:0]  DFAI_KEEP_RST    = 8'h00;
   localparam logic [7:0]  DFAI_SPARE_RST   = 8'h00;
   localparam logic [15:0] DFAI_READING_RST = 16'h0000;
   localparam logic [31:0] DFAI_GAIN_RST    = 32'h0000_0000;
   localparam int          DFAI_AMODE_ONE_BIT = 0;
   localparam int          DFAI_AMODE_TWO_BIT = 1;
   localparam logic [7:0]  DFAI_FIELD_FW    = 8'h00;
   localparam logic [7:0]  DFAI_FIELD_POS   = 8'h01;
   localparam logic [7:0]  DFAI_FIELD_NEG   = 8'hff;
   localparam logic [7:0]  DFAI_KEEP_ON     = 8'h01;
   // Full scales in mV and uA, counts per full scale
   localparam int          DFAI_VOLT_FS_MV  = 10 * 1000;
   localparam int          DFAI_CURR_FS_UA  = 20 * 1000;
   localparam int          DFAI_FS_COUNTS   = 1024;
   localparam int          DFAI_TUNE_CYC    = 16;

   typedef enum logic [1:0] {DFAI_DIR_FW, DFAI_DIR_POS, DFAI_DIR_NEG} dfai_dir_e;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] index;
      logic [7:0]  subindex;
      logic [31:0] wdata;
   } dfai_req_s;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } dfai_rsp_s;

   typedef struct packed {
      logic [31:0] amode;
      logic [7:0]  field;
      logic [7:0]  keep;
   } dfai_nv_s;
endpackage
`default_nettype wire

// ==== rtl/dfai_regs.sv ====
// Drive flags, analog readings and analog mode objects behind the object port
`default_nettype none
module dfai_regs #(
   parameter int               NUM_GAINS   = 12,
   parameter int               TUNE_CYC    = dfai_pkg::DFAI_TUNE_CYC,
   parameter logic [12*32-1:0] PRESET_STEP = '0,
   parameter logic [12*32-1:0] PRESET_BLDC = '0
) (
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   input  wire dfai_pkg::dfai_req_s          od_req,
   output dfai_pkg::dfai_rsp_s               od_rsp,
   input  wire logic                         nv_load,
   input  wire dfai_pkg::dfai_nv_s           nv_in,
   output dfai_pkg::dfai_nv_s                nv_out,
   input  wire logic                         controller_restart,
   input  wire logic                         tune_start,
   input  wire logic                         motor_is_bldc,
   output logic                              tune_busy,
   output logic                              tune_done,
   output logic                              tune_required,
   output dfai_pkg::dfai_dir_e               field_dir,
   input  wire logic signed [15:0]           adc_one,
   input  wire logic signed [15:0]           adc_two,
   output logic signed [15:0]                reading_one,
   output logic signed [15:0]                reading_two,
   output logic signed [31:0]                scaled_one,
   output logic signed [31:0]                scaled_two,
   output logic                              analog_in_one_current_sel,
   output logic                              analog_in_two_current_sel,
   output logic              [NUM_GAINS-1:0][31:0] gains
);
   import dfai_pkg::*;

   if (TUNE_CYC < 2 || TUNE_CYC > 255) begin : g_bad_tune
      $error("TUNE_CYC out of range");
   end

   typedef enum {DFAI_TUNE_IDLE, DFAI_TUNE_RUN} dfai_tune_e;

   function automatic dfai_dir_e dfai_dir_of(input logic [7:0] v);
      if (v == DFAI_FIELD_POS) return DFAI_DIR_POS;
      if (v == DFAI_FIELD_NEG) return DFAI_DIR_NEG;
      return DFAI_DIR_FW;
   endfunction

   // Scaled units: mV in voltage mode, uA in current mode
   function automatic logic signed [31:0] dfai_scale(input logic signed [15:0] cnt,
                                                     input logic cur);
      logic signed [31:0] fs;
      fs = cur ? 32'(DFAI_CURR_FS_UA) : 32'(DFAI_VOLT_FS_MV);
      return (32'(cnt) * fs) / 32'(DFAI_FS_COUNTS);
   endfunction

   // Object registers and response
   logic [31:0] amode_r, amode_nxt;
   logic [7:0]  field_r, field_nxt;
   logic [7:0]  keep_r, keep_nxt;
   dfai_rsp_s   rsp_r, rsp_nxt;
   logic        gain_wr;

   always_comb begin
      amode_nxt = amode_r;
      field_nxt = field_r;
      keep_nxt  = keep_r;
      gain_wr   = 1'b0;
      rsp_nxt   = '0;
      rsp_nxt.ack = od_req.rd | od_req.wr;
      rsp_nxt.err = od_req.rd | od_req.wr;
      unique case (od_req.index)
         DFAI_IDX_FLAGS: begin
            if (od_req.subindex == DFAI_SUB_COUNT) begin
               rsp_nxt.err   = od_req.wr;
               rsp_nxt.rdata = {24'h0, DFAI_FLAG_COUNT_RST};
            end else if (od_req.subindex == DFAI_SUB_SPARE) begin
               rsp_nxt.err   = 1'b0;
               rsp_nxt.rdata = {24'h0, DFAI_SPARE_RST};
            end else if (od_req.subindex == DFAI_SUB_FIELD) begin
               rsp_nxt.rdata = {{24{field_r[7]}}, field_r};
               if (od_req.wr && dfai_dir_of(od_req.wdata[7:0]) == DFAI_DIR_FW
                   && od_req.wdata[7:0] != DFAI_FIELD_FW) begin
                  rsp_nxt.err = 1'b1;
               end else begin
                  rsp_nxt.err = 1'b0;
                  if (od_req.wr) field_nxt = od_req.wdata[7:0];
               end
            end else if (od_req.subindex == DFAI_SUB_KEEP) begin
               rsp_nxt.err   = 1'b0;
               rsp_nxt.rdata = {{24{keep_r[7]}}, keep_r};
               if (od_req.wr) keep_nxt = od_req.wdata[7:0];
            end
         end
         DFAI_IDX_ANALOG: begin
            rsp_nxt.err = od_req.wr;
            if (od_req.subindex == DFAI_SUB_COUNT) begin
               rsp_nxt.rdata = {24'h0, DFAI_ANALOG_COUNT_RST};
            end else if (od_req.subindex == DFAI_SUB_AIN_ONE) begin
               rsp_nxt.rdata = 32'(reading_one);
            end else if (od_req.subindex == DFAI_SUB_AIN_TWO) begin
               rsp_nxt.rdata = 32'(reading_two);
            end else begin
               rsp_nxt.err = od_req.rd | od_req.wr;
            end
         end
         DFAI_IDX_AMODE: begin
            if (od_req.subindex == DFAI_SUB_COUNT) begin
               rsp_nxt.err   = 1'b0;
               rsp_nxt.rdata = amode_r;
               if (od_req.wr) begin
                  amode_nxt = {30'h0, od_req.wdata[1:0]};
               end
            end
         end
         DFAI_IDX_GAINS: begin
            if (od_req.subindex == DFAI_SUB_COUNT) begin
               rsp_nxt.err   = od_req.wr;
               rsp_nxt.rdata = {24'h0, DFAI_GAIN_COUNT_RST};
            end else if (od_req.subindex <= 8'(NUM_GAINS)) begin
               rsp_nxt.err   = 1'b0;
               rsp_nxt.rdata = gains[od_req.subindex - 8'h01];
               gain_wr       = od_req.wr;
            end
         end
         default: begin
         end
      endcase
      if (nv_load) begin
         amode_nxt = {30'h0, nv_in.amode[1:0]};
         field_nxt = nv_in.field;
         keep_nxt  = nv_in.keep;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         amode_r <= DFAI_AMODE_RST;
         field_r <= DFAI_FIELD_RST;
         keep_r  <= DFAI_KEEP_RST;
         rsp_r   <= '0;
      end else begin
         amode_r <= amode_nxt;
         field_r <= field_nxt;
         keep_r  <= keep_nxt;
         rsp_r   <= rsp_nxt;
      end
   end

   assign od_rsp = rsp_r;
   assign nv_out = '{amode: amode_r, field: field_r, keep: keep_r};
   assign analog_in_one_current_sel = amode_r[DFAI_AMODE_ONE_BIT];
   assign analog_in_two_current_sel = amode_r[DFAI_AMODE_TWO_BIT];

   // Active field direction and tuning-due flag
   dfai_dir_e dir_r, dir_nxt;
   logic      treq_r, treq_nxt;
   logic      done_r, done_nxt;

   always_comb begin
      dir_nxt  = dir_r;
      treq_nxt = treq_r;
      if (done_r) treq_nxt = 1'b0;
      if (controller_restart) begin
         dir_nxt = dfai_dir_of(field_r);
         if (dfai_dir_of(field_r) != dir_r) treq_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dir_r  <= DFAI_DIR_FW;
         treq_r <= 1'b0;
      end else begin
         dir_r  <= dir_nxt;
         treq_r <= treq_nxt;
      end
   end

   assign field_dir     = dir_r;
   assign tune_required = treq_r;

   // Auto tuning sequencer
   dfai_tune_e tst_r, tst_nxt;
   logic [7:0] tcnt_r, tcnt_nxt;
   logic       tkeep_r, tkeep_nxt;
   logic       load_r, load_nxt;

   always_comb begin
      tst_nxt   = tst_r;
      tcnt_nxt  = tcnt_r;
      tkeep_nxt = tkeep_r;
      done_nxt  = 1'b0;
      load_nxt  = 1'b0;
      unique case (tst_r)
         DFAI_TUNE_IDLE: begin
            if (tune_start) begin
               tst_nxt   = DFAI_TUNE_RUN;
               tcnt_nxt  = 8'h00;
               tkeep_nxt = (keep_r == DFAI_KEEP_ON);
            end
         end
         DFAI_TUNE_RUN: begin
            tcnt_nxt = tcnt_r + 8'h01;
            if (tcnt_r == 8'(TUNE_CYC - 1)) begin
               tst_nxt  = DFAI_TUNE_IDLE;
               done_nxt = 1'b1;
               load_nxt = !tkeep_r;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tst_r   <= DFAI_TUNE_IDLE;
         tcnt_r  <= 8'h00;
         tkeep_r <= 1'b0;
         done_r  <= 1'b0;
         load_r  <= 1'b0;
      end else begin
         tst_r   <= tst_nxt;
         tcnt_r  <= tcnt_nxt;
         tkeep_r <= tkeep_nxt;
         done_r  <= done_nxt;
         load_r  <= load_nxt;
      end
   end

   assign tune_busy = (tst_r == DFAI_TUNE_RUN);
   assign tune_done = done_r;

   dfai_gain_store #(
      .NUM_GAINS   (NUM_GAINS),
      .PRESET_STEP (PRESET_STEP),
      .PRESET_BLDC (PRESET_BLDC)
   ) u_gains (
      .clk       (clk),
      .rst_b     (rst_b),
      .wr_en     (gain_wr && !load_r),
      .wr_sub    (od_req.subindex),
      .wr_data   (od_req.wdata),
      .load_en   (load_r),
      .load_bldc (motor_is_bldc),
      .gains     (gains)
   );

   // Analog readings and scaled values
   logic signed [15:0] rd_one_r, rd_two_r;
   logic signed [31:0] sc_one_r, sc_two_r, sc_one_nxt, sc_two_nxt;

   always_comb begin
      sc_one_nxt = dfai_scale(rd_one_r, amode_r[DFAI_AMODE_ONE_BIT]);
      sc_two_nxt = dfai_scale(rd_two_r, amode_r[DFAI_AMODE_TWO_BIT]);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_one_r <= DFAI_READING_RST;
         rd_two_r <= DFAI_READING_RST;
         sc_one_r <= '0;
         sc_two_r <= '0;
      end else begin
         rd_one_r <= adc_one;
         rd_two_r <= adc_two;
         sc_one_r <= sc_one_nxt;
         sc_two_r <= sc_two_nxt;
      end
   end

   assign reading_one = rd_one_r;
   assign reading_two = rd_two_r;
   assign scaled_one  = sc_one_r;
   assign scaled_two  = sc_two_r;

   // Preset load shows TUNE_CYC + 1 edges after the start edge
   localparam int TUNE_WAIT = TUNE_CYC;
   localparam int TUNE_LIM  = TUNE_CYC + 1;

   field_map_a: assert property (@(posedge clk) disable iff (!rst_b)
      $past(controller_restart) && $past(field_r) == 8'hff |-> field_dir == DFAI_DIR_NEG)
      else $error("field override -1 did not force negative");
   field_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      !$past(controller_restart) |-> $stable(field_dir))
      else $error("field direction changed without restart");
   preset_load_a: assert property (@(posedge clk) disable iff (!rst_b)
      tune_start && !tune_busy && keep_r == 8'h00 |-> ##[TUNE_WAIT:TUNE_LIM] load_r)
      else $error("preset not loaded after tuning");
   keep_gains_a: assert property (@(posedge clk) disable iff (!rst_b)
      done_r && tkeep_r |-> !load_r)
      else $error("gains loaded while keep-tuning set");
   reading_track_a: assert property (@(posedge clk) disable iff (!rst_b)
      $past(rst_b) |-> reading_one == $past(adc_one) && reading_two == $past(adc_two))
      else $error("analog reading does not follow input");
   volt_scale_a: assert property (@(posedge clk) disable iff (!rst_b)
      $past(rd_one_r) == 16'sd1024 && !$past(amode_r[0]) |-> scaled_one == 32'sd10000)
      else $error("voltage scale wrong");
   curr_scale_a: assert property (@(posedge clk) disable iff (!rst_b)
      $past(rd_two_r) == 16'sd1024 && $past(amode_r[1]) |-> scaled_two == 32'sd20000)
      else $error("current scale wrong");
   mode_upper_a: assert property (@(posedge clk) disable iff (!rst_b)
      $past(od_req.rd) && $past(od_req.index) == 16'h3221 |-> od_rsp.rdata[31:2] == 30'h0)
      else $error("mode word upper bits not zero");
   mode_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      od_req.wr && od_req.index == 16'h3221 && od_req.subindex == 8'h00 && !nv_load
      |=> analog_in_two_current_sel == $past(od_req.wdata[1]))
      else $error("mode write not applied");

   tune_keep_c: cover property (@(posedge clk) disable iff (!rst_b) done_r && tkeep_r);
   tune_load_c: cover property (@(posedge clk) disable iff (!rst_b) load_r);
   field_neg_c: cover property (@(posedge clk) disable iff (!rst_b) field_dir == DFAI_DIR_NEG);
   curr_mode_c: cover property (@(posedge clk) disable iff (!rst_b) analog_in_one_current_sel);
endmodule
`default_nettype wire
